// ==== hdl/sea_core.sv ====
// Purpose: Two-wire slave access engine for a 16K x 8 non-volatile array
// Assumes: ref_clk far faster than the bus clock; open-drain data line
// Notes:   Bytes of a write land in a page buffer and are programmed after stop
`timescale 1ns/1ns
`default_nettype none
module sea_core
   import sea_pkg::*;
#(
   parameter int WR_CYCLES  = WR_CYCLES_DFLT,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DFLT
)(
   input wire logic       ref_clk,
   input wire logic       sys_rst,
   input wire logic       scl_i,
   input wire logic       sda_i,
   output logic           sda_o,
   output logic           sda_oe_n,
   input wire logic       write_protect,
   input wire logic [2:0] chip_select_straps,
   output logic           write_busy
);
   localparam int CW = $clog2(WR_CYCLES + 1);

   if (WR_CYCLES < MIN_PROG_CYCLES) begin : g_chk
      $error("sea_core: WR_CYCLES too short to empty the page buffer");
   end

   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] s1_q;
   logic [PIN_N-1:0] s2_q;
   logic [PIN_N-1:0] s3_q;
   logic [PIN_N-1:0] filt_q;
   logic             scl_p_q;
   logic             sda_p_q;
   logic             scl_f;
   logic             sda_f;
   logic             wp_f;
   logic [2:0]       straps_f;
   logic             scl_rise;
   logic             scl_fall;
   logic             start_ev;
   logic             stop_ev;
   sea_state_t       st_q;
   sea_kind_t        kind_q;
   logic [3:0]       bcnt_q;
   logic [7:0]       sr_q;
   logic [7:0]       tsr_q;
   logic             rd_mode_q;
   logic             mack_q;
   logic             busy_q;
   logic             wr_pend_q;
   logic [HI_W-1:0]  hi_q;
   logic [ADDR_W-1:0] addr_q;
   logic [PAGE_N-1:0] pvalid_q;
   logic [PAGE_W:0]  sidx_q;
   logic             sph_q;
   logic [1:0]       dcnt_q;
   logic [CW-1:0]    wr_cnt_q;
   logic             oe_n_q;
   logic             sda_lvl_q;
   logic             dev_match;
   logic             rx_done;
   logic             ack_ok;
   logic             pbuf_we;
   logic             ack_end;
   logic             tx_load;
   logic             scan_done;
   logic             prog_done;
   logic [DATA_W-1:0] pbuf_rd;
   logic [DATA_W-1:0] arr_rd;

   sea_stream_if #(.DW(FIFO_W)) push_if ();
   sea_stream_if #(.DW(FIFO_W)) pop_if ();

   // Three-stage sampling; a value counts once stages two and three agree
   assign pin_raw = {write_protect, chip_select_straps, scl_i, sda_i};
   for (genvar i = 0; i < PIN_N; i++) begin : g_sync
      always_ff @(posedge ref_clk) begin
         if (sys_rst) begin
            s1_q[i]   <= PIN_RST[i];
            s2_q[i]   <= PIN_RST[i];
            s3_q[i]   <= PIN_RST[i];
            filt_q[i] <= PIN_RST[i];
         end else begin
            s1_q[i] <= pin_raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               filt_q[i] <= s3_q[i];
            end
         end
      end
   end

   assign scl_f    = filt_q[PIN_SCL];
   assign sda_f    = filt_q[PIN_SDA];
   assign wp_f     = filt_q[PIN_WP];
   assign straps_f = filt_q[PIN_CS0 +: 3];

   // Previous filtered levels for edge and condition detection
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         scl_p_q <= PIN_RST[PIN_SCL];
         sda_p_q <= PIN_RST[PIN_SDA];
      end else begin
         scl_p_q <= scl_f;
         sda_p_q <= sda_f;
      end
   end

   // Start and stop are data edges while the clock stays high
   assign scl_rise = scl_f && !scl_p_q;
   assign scl_fall = !scl_f && scl_p_q;
   assign start_ev = scl_f && scl_p_q && !sda_f && sda_p_q;
   assign stop_ev  = scl_f && scl_p_q && sda_f && !sda_p_q;

   // Byte decode: which received bytes earn an acknowledge
   assign dev_match = (sr_q[7:4] == DEV_TYPE) && (sr_q[3:1] == straps_f);
   assign rx_done   = (st_q == ST_RX) && scl_fall && (bcnt_q == BYTE_BITS);
   always_comb begin
      case (kind_q)
         K_DEV:   ack_ok = dev_match;
         K_DATA:  ack_ok = !wp_f;
         default: ack_ok = 1'b1;
      endcase
   end
   assign pbuf_we = rx_done && (kind_q == K_DATA) && !wp_f;
   assign ack_end = (st_q == ST_ACK) && scl_fall;
   assign tx_load = (ack_end && rd_mode_q) || ((st_q == ST_RACK) && scl_fall && mack_q);

   // Bus state machine; a running program cycle shuts the bus out
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q      <= ST_IDLE;
         kind_q    <= K_DEV;
         bcnt_q    <= '0;
         rd_mode_q <= 1'b0;
         mack_q    <= 1'b0;
         busy_q    <= 1'b0;
      end else if (st_q == ST_PROG) begin
         if (prog_done) begin
            st_q   <= ST_IDLE;
            busy_q <= 1'b0;
         end
      end else if (start_ev) begin
         st_q      <= ST_RX;
         kind_q    <= K_DEV;
         bcnt_q    <= '0;
         rd_mode_q <= 1'b0;
      end else if (stop_ev) begin
         st_q   <= wr_pend_q ? ST_PROG : ST_IDLE;
         busy_q <= wr_pend_q;
      end else begin
         case (st_q)
            ST_RX: begin
               if (scl_rise) begin
                  bcnt_q <= bcnt_q + 4'h1;
               end else if (rx_done) begin
                  st_q <= ack_ok ? ST_ACK : ST_IDLE;
                  case (kind_q)
                     K_DEV: begin
                        rd_mode_q <= sr_q[SR_RW_BIT];
                        kind_q    <= K_ADDR_HI;
                     end
                     K_ADDR_HI: kind_q <= K_ADDR_LO;
                     default:   kind_q <= K_DATA;
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  st_q   <= rd_mode_q ? ST_TX : ST_RX;
                  bcnt_q <= '0;
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bcnt_q <= bcnt_q + 4'h1;
               end else if (scl_fall && bcnt_q == BYTE_BITS) begin
                  st_q <= ST_RACK;
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  mack_q <= !sda_f;
               end else if (scl_fall) begin
                  st_q   <= mack_q ? ST_TX : ST_IDLE;
                  bcnt_q <= '0;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Receive shift register, sampled on the rising clock
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sr_q <= '0;
      end else if (st_q == ST_RX && scl_rise) begin
         sr_q <= {sr_q[6:0], sda_f};
      end
   end

   // Address counter: loaded from word address, advanced by each access
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         hi_q   <= '0;
         addr_q <= '0;
      end else if (rx_done && kind_q == K_ADDR_HI) begin
         hi_q <= sr_q[HI_W-1:0];
      end else if (rx_done && kind_q == K_ADDR_LO) begin
         addr_q <= {hi_q, sr_q};
      end else if (pbuf_we) begin
         addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 1'b1;
      end else if (tx_load) begin
         addr_q <= addr_q + 1'b1;
      end
   end

   // Pending write and page buffer occupancy; a new start drops an unfinished page
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_pend_q <= 1'b0;
         pvalid_q  <= '0;
      end else if (st_q == ST_PROG) begin
         wr_pend_q <= 1'b0;
         if (prog_done) begin
            pvalid_q <= '0;
         end
      end else if (start_ev) begin
         wr_pend_q <= 1'b0;
         pvalid_q  <= '0;
      end else if (pbuf_we) begin
         wr_pend_q                       <= 1'b1;
         pvalid_q[addr_q[PAGE_W-1:0]]    <= 1'b1;
      end
   end

   // Page buffer; a wrapped address overwrites the earlier byte in place
   sea_mem #(.AW(PAGE_W), .DW(DATA_W)) u_pbuf (
      .ref_clk (ref_clk),
      .we      (pbuf_we),
      .wr_addr (addr_q[PAGE_W-1:0]),
      .wr_data (sr_q),
      .rd_addr (sidx_q[PAGE_W-1:0]),
      .rd_data (pbuf_rd)
   );

   // Page scan: two cycles per entry, more while the FIFO is full, so read data matches the index
   assign scan_done    = sidx_q[PAGE_W];
   assign push_if.valid = busy_q && sph_q && !scan_done && pvalid_q[sidx_q[PAGE_W-1:0]];
   assign push_if.data  = {addr_q[ADDR_W-1:PAGE_W], sidx_q[PAGE_W-1:0], pbuf_rd};
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !busy_q) begin
         sidx_q <= '0;
         sph_q  <= 1'b0;
      end else if (!scan_done) begin
         if (!sph_q) begin
            sph_q <= 1'b1;
         end else if (!push_if.valid || push_if.ready) begin
            sidx_q <= sidx_q + 1'b1;
            sph_q  <= 1'b0;
         end
      end
   end

   sea_fifo #(.DW(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .in_s    (push_if),
      .out_s   (pop_if)
   );

   // Array programming drains slower than the scan fills, trading speed for a real stall path
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dcnt_q <= '0;
      end else begin
         dcnt_q <= dcnt_q + 2'h1;
      end
   end
   assign pop_if.ready = (dcnt_q == DRAIN_LAST);

   sea_mem #(.AW(ADDR_W), .DW(DATA_W)) u_array (
      .ref_clk (ref_clk),
      .we      (pop_if.valid && pop_if.ready),
      .wr_addr (pop_if.data[FIFO_W-1:DATA_W]),
      .wr_data (pop_if.data[DATA_W-1:0]),
      .rd_addr (addr_q),
      .rd_data (arr_rd)
   );

   // Self-timed write: always the full count, never longer
   assign prog_done = busy_q && scan_done && !pop_if.valid && (wr_cnt_q == CW'(WR_CYCLES - 1));
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !busy_q) begin
         wr_cnt_q <= '0;
      end else if (wr_cnt_q != CW'(WR_CYCLES - 1)) begin
         wr_cnt_q <= wr_cnt_q + 1'b1;
      end
   end

   // Transmit shift register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tsr_q <= '0;
      end else if (tx_load) begin
         tsr_q <= arr_rd;
      end else if (st_q == ST_TX && scl_fall) begin
         tsr_q <= {tsr_q[6:0], 1'b0};
      end
   end

   // Data line drive: changes on falling clock, forced released at start, stop and while busy; released by default
   always_ff @(posedge ref_clk) begin
      if (sys_rst || busy_q || start_ev || stop_ev) begin
         oe_n_q <= 1'b1;
      end else if (rx_done) begin
         oe_n_q <= !ack_ok;
      end else if (tx_load) begin
         oe_n_q <= arr_rd[7];
      end else if (st_q == ST_TX && scl_fall && bcnt_q != BYTE_BITS) begin
         oe_n_q <= tsr_q[6];
      end else if (scl_fall) begin
         oe_n_q <= 1'b1;
      end
   end

   // Open drain: the level driven is always low
   always_ff @(posedge ref_clk) begin
      sda_lvl_q <= 1'b0;
   end

   assign sda_o      = sda_lvl_q;
   assign sda_oe_n   = oe_n_q;
   assign write_busy = busy_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_stop_seen;
      stop_ev && wr_pend_q;
   endsequence
   sequence s_prog_begins;
      busy_q && st_q == ST_PROG;
   endsequence

   property p_prog_at_stop;
      $rose(busy_q) |-> $past(stop_ev) && $past(wr_pend_q);
   endproperty
   a_prog_at_stop: assert property (p_prog_at_stop) else $error("program began without stop");

   property p_stop_starts;
      s_stop_seen ##0 (st_q != ST_PROG) |=> s_prog_begins;
   endproperty
   a_stop_starts: assert property (p_stop_starts) else $error("stop did not start program");

   property p_quiet_busy;
      busy_q |-> sda_oe_n;
   endproperty
   a_quiet_busy: assert property (p_quiet_busy) else $error("data line driven while busy");

   property p_write_bound;
      busy_q && wr_cnt_q == CW'(WR_CYCLES - 1) |=> !busy_q;
   endproperty
   a_write_bound: assert property (p_write_bound) else $error("write time exceeded");

   property p_page_wrap;
      pbuf_we |=> addr_q[ADDR_W-1:PAGE_W] == $past(addr_q[ADDR_W-1:PAGE_W])
              && addr_q[PAGE_W-1:0] == $past(addr_q[PAGE_W-1:0]) + 1'b1;
   endproperty
   a_page_wrap: assert property (p_page_wrap) else $error("page address left its page");

   property p_protect;
      rx_done && kind_q == K_DATA && wp_f |=> sda_oe_n && st_q == ST_IDLE;
   endproperty
   a_protect: assert property (p_protect) else $error("protected data acknowledged");

   property p_bad_select;
      rx_done && kind_q == K_DEV && !dev_match |=> st_q == ST_IDLE && sda_oe_n;
   endproperty
   a_bad_select: assert property (p_bad_select) else $error("answered a foreign address");

   property p_read_step;
      tx_load |=> addr_q == $past(addr_q) + 1'b1;
   endproperty
   a_read_step: assert property (p_read_step) else $error("read counter did not advance");

   property p_nack_ends;
      st_q == ST_RACK && scl_fall && !mack_q && !start_ev && !stop_ev |=> st_q == ST_IDLE ##1 sda_oe_n;
   endproperty
   a_nack_ends: assert property (p_nack_ends) else $error("read went on after no ack");
endmodule
`default_nettype wire

// ==== hdl/sea_pkg.sv ====
// Purpose: Shared constants and types of the serial memory access engine
// Assumes: 100 MHz sampling clock, 16K x 8 array, 64-byte pages
// Notes:   Shared sizes, pin indices and timings are named here; bit slices and the strap width stay literal in the core
package sea_pkg;

   // Array geometry
   localparam int ADDR_W   = 14;
   localparam int PAGE_W   = 6;
   localparam int DATA_W   = 8;
   localparam int PAGE_N   = 64;
   localparam int HI_W     = ADDR_W - DATA_W;
   localparam int FIFO_W   = ADDR_W + DATA_W;

   // Slave address fields
   localparam logic [3:0] DEV_TYPE  = 4'ha;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int         SR_RW_BIT = 0;

   // Input pin sampling: index of each pin in the synchroniser vector
   localparam int         PIN_N    = 6;
   localparam int         PIN_SDA  = 0;
   localparam int         PIN_SCL  = 1;
   localparam int         PIN_CS0  = 2;
   localparam int         PIN_WP   = 5;
   localparam logic [5:0] PIN_RST  = 6'h03;   // Bus lines idle high

   // Internal write time and its cycle count (longest time rounds down)
   localparam int WR_TIME_US      = 6000;
   localparam int CLK_MHZ         = 100;
   localparam int WR_CYCLES_DFLT  = WR_TIME_US * CLK_MHZ;
   localparam int MIN_PROG_CYCLES = 512;

   // Page buffer to array transfer
   localparam int         FIFO_DEPTH_DFLT = 8;
   localparam logic [1:0] DRAIN_LAST      = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX   = 3'b001,
      ST_ACK  = 3'b010,
      ST_TX   = 3'b011,
      ST_RACK = 3'b100,
      ST_PROG = 3'b101
   } sea_state_t;

   typedef enum logic [1:0] {
      K_DEV     = 2'b00,
      K_ADDR_HI = 2'b01,
      K_ADDR_LO = 2'b10,
      K_DATA    = 2'b11
   } sea_kind_t;

endpackage

// ==== hdl/sea_store.sv ====
// Purpose: Storage leaves: a small word FIFO and a registered-read memory
// Assumes: Single clock, synchronous active-high reset
// Notes:   Memory contents have no reset, as in a real array
`timescale 1ns/1ns
`default_nettype none
module sea_fifo
   import sea_pkg::*;
#(
   parameter int DW    = FIFO_W,
   parameter int DEPTH = FIFO_DEPTH_DFLT
)(
   input wire logic ref_clk,
   input wire logic sys_rst,
   sea_stream_if.snk in_s,
   sea_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);

   logic [DW-1:0] mem_q [DEPTH];
   logic [AW:0]   wp_q;
   logic [AW:0]   rp_q;
   logic          full;
   logic          empty;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("sea_fifo: DEPTH must be a power of two, at least 2");
   end

   // Full when pointers differ only in the wrap bit
   assign full        = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   assign empty       = (wp_q == rp_q);
   assign in_s.ready  = !full;
   assign out_s.valid = !empty;
   assign out_s.data  = mem_q[rp_q[AW-1:0]];

   // Write side
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wp_q <= '0;
      end else if (in_s.valid && !full) begin
         mem_q[wp_q[AW-1:0]] <= in_s.data;
         wp_q                <= wp_q + 1'b1;
      end
   end

   // Read side
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rp_q <= '0;
      end else if (out_s.ready && !empty) begin
         rp_q <= rp_q + 1'b1;
      end
   end
endmodule

module sea_mem #(
   parameter int AW = 14,
   parameter int DW = 8
)(
   input wire logic          ref_clk,
   input wire logic          we,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0]     rd_data
);
   logic [DW-1:0] mem_q [1 << AW];

   // One write port, read data from a register
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem_q[wr_addr] <= wr_data;
      end
      rd_data <= mem_q[rd_addr];
   end
endmodule
`default_nettype wire

// ==== hdl/sea_stream_if.sv ====
// Purpose: Valid/ready word stream between the engine and its FIFO
// Assumes: Both ends on the same clock
// Notes:   Source drives valid and data, sink drives ready
`timescale 1ns/1ns
`default_nettype none
interface sea_stream_if #(parameter int DW = 8);
   logic          valid;
   logic          ready;
   logic [DW-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== sim/sea_master.sv ====
// Purpose: Behavioural two-wire bus master for the access engine
// Assumes: Open-drain data line with pull-up, resolved in the bench
// Notes:   Phases of 8 ref_clk cycles keep the engine's sampler margins
`timescale 1ns/1ns
`default_nettype none
module sea_master (
   input wire logic ref_clk,
   output logic     scl,
   output logic     sda_drv,
   input wire logic sda_bus
);
   // Bus idles released high
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end

   // One phase; also the data hold after a clock fall
   task automatic ph();
      repeat (8) @(posedge ref_clk);
   endtask

   // Start or repeated start: data falls while clock high
   task automatic start();
      sda_drv <= 1'b1;
      ph();
      scl <= 1'b1;
      ph();
      sda_drv <= 1'b0;
      ph();
      scl <= 1'b0;
      ph();
   endtask

   // Stop: data rises while clock high
   task automatic stop();
      sda_drv <= 1'b0;
      ph();
      scl <= 1'b1;
      ph();
      sda_drv <= 1'b1;
      ph();
   endtask

   // One bit; sampled late in the high phase so the slave has settled
   task automatic bit_io(input logic b, output logic r);
      sda_drv <= b;
      ph();
      scl <= 1'b1;
      ph();
      r = sda_bus;
      scl <= 1'b0;
      ph();
   endtask

   // Byte out MSB first, then the ninth clock with the line released
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   // Byte in; master ack asks for more, nack ends the read
   task automatic read_byte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~mack, r);
   endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the serial memory access engine
// Assumes: Shortened internal write time; straps fixed for the run
// Notes:   Expected array contents are worked out here from the address rules
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import sea_pkg::*;
   ;
   localparam int         WRC    = 600;
   localparam logic [2:0] STRAPS = 3'h5;
   localparam logic [7:0] DEV_W  = {DEV_TYPE, STRAPS, 1'b0};

   logic       ref_clk;
   logic       sys_rst;
   logic       write_protect;
   logic       scl;
   logic       sda_drv;
   logic       sda_bus;
   logic       sda_o;
   logic       sda_oe_n;
   logic       write_busy;
   logic [2:0] straps;
   int         bad_count;
   int         tests_run;
   int         busy_len;

   // Open-drain wire with pull-up: low if either side pulls
   assign sda_bus = sda_drv & (sda_oe_n | sda_o);

   // Internal write length, counted on every rising edge that sees busy high
   always @(posedge ref_clk) begin
      if (write_busy === 1'b1) begin
         busy_len <= busy_len + 1;
      end
   end

   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   sea_core #(.WR_CYCLES(WRC), .FIFO_DEPTH(8)) dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda_bus),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .write_protect(write_protect),
      .chip_select_straps(straps), .write_busy(write_busy));

   sea_master m (.ref_clk(ref_clk), .scl(scl), .sda_drv(sda_drv), .sda_bus(sda_bus));

   // Comparisons of single flags and of data bytes
   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Write-direction slave address and both word address bytes
   task automatic addr(input logic [7:0] hi, input logic [7:0] lo);
      logic a;
      m.start();
      m.write_byte(DEV_W, a);
      chk_bit(a, 1'b1);
      m.write_byte(hi, a);
      chk_bit(a, 1'b1);
      m.write_byte(lo, a);
      chk_bit(a, 1'b1);
   endtask

   // Acknowledge poll: start, write slave address, stop
   task automatic poll(input logic exp);
      logic a;
      m.start();
      m.write_byte(DEV_W, a);
      m.stop();
      chk_bit(a, exp);
   endtask

   // Full write; program must wait for stop and end in bounded time
   task automatic wr(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d[$]);
      logic a;
      int   n;
      addr(hi, lo);
      foreach (d[i]) begin
         m.write_byte(d[i], a);
         chk_bit(a, 1'b1);
      end
      @(negedge ref_clk);
      chk_bit(write_busy, 1'b0);
      @(posedge ref_clk);
      busy_len = 0;
      m.stop();
      @(negedge ref_clk);
      chk_bit(write_busy, 1'b1);
      @(posedge ref_clk);
      poll(1'b0);
      n = 0;
      while (write_busy === 1'b1 && n < WRC + 100) begin
         @(negedge ref_clk);
         n++;
      end
      chk_bit(write_busy, 1'b0);
      chk_bit(busy_len > 0 && busy_len <= WRC, 1'b1);
      @(posedge ref_clk);
      poll(1'b1);
   endtask

   // Read-direction address, then bytes acked by master but for the last
   task automatic rd_cur(input logic [7:0] e[$]);
      logic       a;
      logic [7:0] v;
      m.start();
      m.write_byte(DEV_W | 8'h01, a);
      chk_bit(a, 1'b1);
      foreach (e[i]) begin
         m.read_byte(i < e.size() - 1, v);
         chk_byte(v, e[i]);
      end
      m.stop();
   endtask

   // Random read: dummy write of the address, then repeated start
   task automatic rd(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] e[$]);
      addr(hi, lo);
      rd_cur(e);
   endtask

   // Byte writes at both array ends and at 0x1000; unused high address bits set on purpose
   task automatic t_byte();
      wr(8'hd0, 8'h00, '{8'h5a});
      wr(8'h3f, 8'hff, '{8'h11});
      wr(8'h00, 8'h00, '{8'h22});
      rd(8'h10, 8'h00, '{8'h5a});
      rd(8'h3f, 8'hff, '{8'h11, 8'h22});
   endtask

   // 66 bytes from two below page end: wrap in page, last two overwrite first
   task automatic t_page();
      logic [7:0] d[$];
      logic [7:0] e[$];
      for (int k = 0; k < PAGE_N + 2; k++) d.push_back(8'(k + 1));
      for (int j = 0; j < PAGE_N; j++) e.push_back(8'h00);
      for (int k = 0; k < PAGE_N + 2; k++) e[(62 + k) % PAGE_N] = d[k];
      wr(8'h0f, 8'hfe, d);
      rd(8'h0f, 8'hc0, e);
      rd_cur('{8'h5a});
   endtask

   // Foreign device type, wrong straps, then a protected write
   task automatic t_refuse();
      logic a;
      m.start();
      m.write_byte({4'h5, STRAPS, 1'b0}, a);
      chk_bit(a, 1'b0);
      m.start();
      m.write_byte({DEV_TYPE, ~STRAPS, 1'b0}, a);
      chk_bit(a, 1'b0);
      m.stop();
      write_protect <= 1'b1;
      addr(8'h10, 8'h00);
      m.write_byte(8'h77, a);
      chk_bit(a, 1'b0);
      m.stop();
      write_protect <= 1'b0;
      @(negedge ref_clk);
      chk_bit(write_busy, 1'b0);
      @(posedge ref_clk);
      rd(8'h90, 8'h00, '{8'h5a});
   endtask

   // Main sequence
   initial begin
      sys_rst       = 1'b1;
      write_protect = 1'b0;
      straps        = STRAPS;
      bad_count     = 0;
      tests_run     = 0;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge ref_clk);
      t_byte();
      t_page();
      t_refuse();
      test_done();
   end

   // Watchdog at more than twice the expected run
   initial begin
      #1000000;
      bad_count++;
      test_done();
   end
endmodule
`default_nettype wire
